// ==== pkg/adsel_pkg.sv ====
// adsel_pkg: constants and carrier types for the antenna diversity selector.
// assumes a single 20 MHz clock and synchronous active-high reset.
`default_nettype none

package adsel_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  // multipath skew threshold, fixed per unit within 125..375 ns
  localparam int SKEW_TD_NS = 250;
  // longest time rounds down, at least one cycle
  localparam int SKEW_TD_CYC_I = (SKEW_TD_NS / CLK_PERIOD_NS) < 1 ? 1 : (SKEW_TD_NS / CLK_PERIOD_NS);
  // decision latency kept fixed so reply delay jitter stays below 80 ns
  localparam int JITTER_MAX_NS = 80;
  localparam int DECIDE_LAT_CYC = 1;

  localparam int AMP_W = 8;
  localparam int TIME_W = 16;
  localparam logic [TIME_W-1:0] SKEW_TD_CYC = TIME_W'(SKEW_TD_CYC_I);
  // amplitude codes: precise compare band is 6 dB above the trigger level
  localparam logic [AMP_W-1:0] AMP_NEAR_MTL = 8'h06;
  // coarse compare ignores the low bits of the amplitude code
  localparam int COARSE_SHIFT = 2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  // one receive channel's report of a detection
  typedef struct packed {
    logic pair_valid;
    logic pair_seen;
    logic msg_valid;
    logic [AMP_W-1:0] amp;
    logic [TIME_W-1:0] toa;
  } adsel_rx_t;

  // channel choice handed to the transmitter switch
  typedef enum logic [1:0] {
    ADSEL_NONE = 2'b00,
    ADSEL_TOP = 2'b01,
    ADSEL_BOT = 2'b10
  } adsel_sel_t;

endpackage : adsel_pkg

`default_nettype wire

// ==== rtl/adsel_ampcmp.sv ====
// adsel_ampcmp: symmetric amplitude compare between two channels.
// assumes amplitude codes are in steps above the minimum trigger level.
`default_nettype none

module adsel_ampcmp
  import adsel_pkg::*;
(
  input wire logic [AMP_W-1:0] amp_a,
  input wire logic [AMP_W-1:0] amp_b,
  output logic a_wins,
  output logic b_wins
);

  logic precise;
  logic [AMP_W-1:0] ca;
  logic [AMP_W-1:0] cb;

  // precise only when both weak; else coarse, cheaper and good enough
  always_comb
  begin
    precise = (amp_a <= AMP_NEAR_MTL) && (amp_b <= AMP_NEAR_MTL);
    ca = precise ? amp_a : (amp_a >> COARSE_SHIFT);
    cb = precise ? amp_b : (amp_b >> COARSE_SHIFT);
    // equal codes give neither side the win
    a_wins = ca > cb;
    b_wins = cb > ca;
  end

endmodule : adsel_ampcmp

`default_nettype wire

// ==== rtl/adsel_top.sv ====
// adsel_top: reply antenna selection for a two-channel diversity transponder.
// assumes rx reports are one-cycle strobes synchronous to clk.
// Overview of operation
// - reply goes to stronger received channel
// - amplitude compare only if both pairs valid
// - single valid channel chosen without comparing
// - decision may wait for message, bounded latency
// - parallel decoders: compare only both messages valid
// - later signal beyond skew is multipath
// - no preference for top or bottom
// - precise compare only near trigger level
// - never alternate antenna at preset rate
// - fixed decision latency keeps delay jitter low
`default_nettype none

module adsel_top
  import adsel_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire adsel_pkg::adsel_rx_t rx_top,
  input wire adsel_pkg::adsel_rx_t rx_bot,
  input wire logic use_msg,
  input wire logic tie_prev_top,
  output adsel_pkg::adsel_sel_t sel_r,
  output logic sel_strobe_r,
  output logic tx_key_r
);

  logic ok_t;
  logic ok_b;
  logic seen;
  logic t_wins;
  logic b_wins;
  logic [TIME_W-1:0] skew_tb;
  logic [TIME_W-1:0] skew_bt;
  adsel_sel_t sel_nxt;

  // ----------------------------------------
  // validity gate
  // ----------------------------------------
  // pair or message mode, chosen by use_msg
  always_comb
  begin
    ok_t = use_msg ? rx_top.msg_valid : rx_top.pair_valid;
    ok_b = use_msg ? rx_bot.msg_valid : rx_bot.pair_valid;
    seen = rx_top.pair_seen | rx_bot.pair_seen;
    skew_tb = rx_top.toa - rx_bot.toa;
    skew_bt = rx_bot.toa - rx_top.toa;
  end

  adsel_ampcmp u_cmp (
    .amp_a(rx_top.amp),
    .amp_b(rx_bot.amp),
    .a_wins(t_wins),
    .b_wins(b_wins)
  );

  // ----------------------------------------
  // decision
  // ----------------------------------------
  always_comb
  begin
    sel_nxt = ADSEL_NONE;
    if (ok_t && !ok_b)
    begin
      sel_nxt = ADSEL_TOP;
    end
    else if (ok_b && !ok_t)
    begin
      sel_nxt = ADSEL_BOT;
    end
    else if (ok_t && ok_b)
    begin
      if (rx_top.toa > rx_bot.toa && skew_tb > SKEW_TD_CYC)
        sel_nxt = ADSEL_BOT;
      else if (rx_bot.toa > rx_top.toa && skew_bt > SKEW_TD_CYC)
        sel_nxt = ADSEL_TOP;
      else if (t_wins)
        sel_nxt = ADSEL_TOP;
      else if (b_wins)
        sel_nxt = ADSEL_BOT;
      // tie follows external hint, not a fixed antenna
      else
        sel_nxt = tie_prev_top ? ADSEL_TOP : ADSEL_BOT;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // sel_r changes only on a received event or on reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sel_r <= ADSEL_NONE;
      sel_strobe_r <= 1'b0;
      tx_key_r <= 1'b0;
    end
    else
    begin
      sel_strobe_r <= seen;
      tx_key_r <= seen && (sel_nxt != ADSEL_NONE);
      if (seen)
        sel_r <= sel_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_lone_top;
    @(posedge clk) disable iff (sys_rst)
    (seen && ok_t && !ok_b) |=> (sel_r == ADSEL_TOP && tx_key_r);
  endproperty
  a_lone_top: assert property (p_lone_top) else $error("lone top not chosen");

  property p_lone_bot;
    @(posedge clk) disable iff (sys_rst)
    (seen && ok_b && !ok_t) |=> (sel_r == ADSEL_BOT && tx_key_r);
  endproperty
  a_lone_bot: assert property (p_lone_bot) else $error("lone bottom not chosen");

  property p_no_key;
    @(posedge clk) disable iff (sys_rst)
    (!ok_t && !ok_b) |=> !tx_key_r;
  endproperty
  a_no_key: assert property (p_no_key) else $error("keyed without valid input");

  property p_stronger;
    @(posedge clk) disable iff (sys_rst)
    (seen && ok_t && ok_b && rx_top.toa == rx_bot.toa && t_wins) |=> sel_r == ADSEL_TOP;
  endproperty
  a_stronger: assert property (p_stronger) else $error("stronger top lost");

  property p_mp_top;
    @(posedge clk) disable iff (sys_rst)
    (seen && ok_t && ok_b && rx_bot.toa > rx_top.toa && skew_bt > SKEW_TD_CYC) |=> sel_r == ADSEL_TOP;
  endproperty
  a_mp_top: assert property (p_mp_top) else $error("multipath bottom chosen");

  property p_mp_bot;
    @(posedge clk) disable iff (sys_rst)
    (seen && ok_t && ok_b && rx_top.toa > rx_bot.toa && skew_tb > SKEW_TD_CYC) |=> sel_r == ADSEL_BOT;
  endproperty
  a_mp_bot: assert property (p_mp_bot) else $error("multipath top chosen");

  property p_hold;
    @(posedge clk) disable iff (sys_rst)
    !seen |=> $stable(sel_r);
  endproperty
  a_hold: assert property (p_hold) else $error("selection moved without event");

  sequence s_event;
    seen && (sel_nxt != ADSEL_NONE);
  endsequence
  property p_latency;
    @(posedge clk) disable iff (sys_rst)
    s_event |=> (sel_strobe_r && tx_key_r);
  endproperty
  a_latency: assert property (p_latency) else $error("decision latency wrong");

  // strobes stand one cycle; back-to-back events may keep them high
  property p_pulse;
    @(posedge clk) disable iff (sys_rst)
    !seen |=> (!sel_strobe_r && !tx_key_r);
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe held without event");

  property p_strobe;
    @(posedge clk) disable iff (sys_rst)
    seen |=> sel_strobe_r;
  endproperty
  a_strobe: assert property (p_strobe) else $error("event not answered");

  // refused event still answers, but with no antenna and no key
  property p_refused;
    @(posedge clk) disable iff (sys_rst)
    (seen && !ok_t && !ok_b) |=> (sel_r == ADSEL_NONE && !tx_key_r);
  endproperty
  a_refused: assert property (p_refused) else $error("selection made without valid input");

  property p_stronger_bot;
    @(posedge clk) disable iff (sys_rst)
    (seen && ok_t && ok_b && rx_top.toa == rx_bot.toa && b_wins) |=> sel_r == ADSEL_BOT;
  endproperty
  a_stronger_bot: assert property (p_stronger_bot) else $error("stronger bottom lost");

  // tie: both valid, same arrival, neither side wins the compare
  sequence s_tie;
    seen && ok_t && ok_b && (rx_top.toa == rx_bot.toa) && !t_wins && !b_wins;
  endsequence

  property p_tie;
    @(posedge clk) disable iff (sys_rst)
    s_tie |=> (sel_r == ($past(tie_prev_top) ? ADSEL_TOP : ADSEL_BOT));
  endproperty
  a_tie: assert property (p_tie) else $error("tie not settled by hint");

  // near the trigger level any difference must decide
  property p_precise;
    @(posedge clk) disable iff (sys_rst)
    (rx_top.amp <= AMP_NEAR_MTL && rx_bot.amp <= AMP_NEAR_MTL && rx_top.amp != rx_bot.amp) |-> (t_wins != b_wins);
  endproperty
  a_precise: assert property (p_precise) else $error("weak signals compared coarsely");

  // message mode: no complete message on either side, no reply
  property p_msg_gate;
    @(posedge clk) disable iff (sys_rst)
    (seen && use_msg && !rx_top.msg_valid && !rx_bot.msg_valid) |=> !tx_key_r;
  endproperty
  a_msg_gate: assert property (p_msg_gate) else $error("keyed without complete message");

  // one shared selector drives exactly one antenna code at a time
  property p_legal;
    @(posedge clk) disable iff (sys_rst)
    sel_r inside {ADSEL_NONE, ADSEL_TOP, ADSEL_BOT};
  endproperty
  a_legal: assert property (p_legal) else $error("illegal antenna code");

endmodule : adsel_top

`default_nettype wire

// ==== dv/adsel_rx_model.sv ====
// adsel_rx_model: top and bottom receive channels in front of the selector.
// assumes the bench raises fire for one cycle per interrogation.
`default_nettype none

module adsel_rx_model
  import adsel_pkg::*;
(
  input wire logic fire,
  input wire adsel_pkg::adsel_rx_t top_in,
  input wire adsel_pkg::adsel_rx_t bot_in,
  output adsel_pkg::adsel_rx_t rx_top,
  output adsel_pkg::adsel_rx_t rx_bot
);
  timeunit 1ns;
  timeprecision 1ns;
  // between events fields are stale: pair_seen reads 0, the rest show their inverse, never a lucky match
  assign rx_top = fire ? top_in : adsel_rx_t'(~top_in & 27'h5ff_ffff);
  assign rx_bot = fire ? bot_in : adsel_rx_t'(~bot_in & 27'h5ff_ffff);
endmodule : adsel_rx_model

`default_nettype wire

// ==== dv/tb_adsel.sv ====
// tb_adsel: self-checking bench for the reply antenna selector.
// assumes a 20 MHz clock and one-cycle event reports from both channels.
`default_nettype none

module tb_adsel;
  import adsel_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, sys_rst = 1, fire = 0, use_msg = 0, tie_prev_top = 0;
  adsel_rx_t t_in = '0, b_in = '0, rx_top, rx_bot;
  adsel_sel_t sel_r;
  logic sel_strobe_r, tx_key_r;
  int num_errors = 0, check_count = 0, cyc = 0;
  always #25 clk = ~clk;
  adsel_rx_model adsel_rx_model_inst (.fire(fire), .top_in(t_in), .bot_in(b_in), .rx_top(rx_top), .rx_bot(rx_bot));
  adsel_top adsel_top_inst (.clk(clk), .sys_rst(sys_rst), .rx_top(rx_top), .rx_bot(rx_bot), .use_msg(use_msg),
    .tie_prev_top(tie_prev_top), .sel_r(sel_r), .sel_strobe_r(sel_strobe_r), .tx_key_r(tx_key_r));
  task automatic chk(string what, logic [1:0] seen, logic [1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s exp %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  function automatic adsel_rx_t rx(logic v, logic m, logic [7:0] a, logic [15:0] t);
    return '{v, 1'b1, m, a, t};
  endfunction : rx
  // one event, answer judged a cycle later, then a quiet cycle
  task automatic ev(adsel_rx_t t, adsel_rx_t b, adsel_sel_t exp);
    t_in = t;
    b_in = b;
    fire = 1;
    @(posedge clk);
    #1 fire = 0;
    chk("sel", sel_r, exp);
    chk("stb", {1'b0, sel_strobe_r}, 2'h1);
    chk("key", {1'b0, tx_key_r}, {1'b0, exp != ADSEL_NONE});
    @(posedge clk);
    #1;
    // no event means no switching, the choice just holds
    chk("hold", sel_r, exp);
    chk("idle", {sel_strobe_r, tx_key_r}, 2'h0);
  endtask : ev
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_single();
    ev(rx(1, 0, 8'h10, 16'h0), rx(0, 0, 8'hff, 16'h0), ADSEL_TOP);
    ev(rx(0, 0, 8'hff, 16'h0), rx(1, 0, 8'h10, 16'h0), ADSEL_BOT);
  endtask : t_single
  task automatic t_amp();
    ev(rx(1, 0, 8'h28, 16'h0), rx(1, 0, 8'hc8, 16'h0), ADSEL_BOT);
    ev(rx(1, 0, 8'hc8, 16'h0), rx(1, 0, 8'h28, 16'h0), ADSEL_TOP);
    // tie pin set against the winner: only the precise compare gets it right
    tie_prev_top = 1;
    ev(rx(1, 0, 8'h05, 16'h0), rx(1, 0, 8'h06, 16'h0), ADSEL_BOT);
    tie_prev_top = 0;
    ev(rx(1, 0, 8'h06, 16'h0), rx(1, 0, 8'h05, 16'h0), ADSEL_TOP);
  endtask : t_amp
  task automatic t_skew();
    ev(rx(1, 0, 8'h10, 16'h64), rx(1, 0, 8'hf0, 16'h65 + SKEW_TD_CYC), ADSEL_TOP);
    ev(rx(1, 0, 8'hf0, 16'h65 + SKEW_TD_CYC), rx(1, 0, 8'h10, 16'h64), ADSEL_BOT);
    ev(rx(1, 0, 8'h10, 16'h64), rx(1, 0, 8'hf0, 16'h64 + SKEW_TD_CYC), ADSEL_BOT);
  endtask : t_skew
  task automatic t_tie();
    tie_prev_top = 1;
    ev(rx(1, 0, 8'h80, 16'h0), rx(1, 0, 8'h80, 16'h0), ADSEL_TOP);
    tie_prev_top = 0;
    ev(rx(1, 0, 8'h80, 16'h0), rx(1, 0, 8'h80, 16'h0), ADSEL_BOT);
  endtask : t_tie
  task automatic t_none();
    ev(rx(0, 0, 8'hff, 16'h0), rx(0, 0, 8'hff, 16'h0), ADSEL_NONE);
  endtask : t_none
  task automatic t_msg();
    use_msg = 1;
    ev(rx(1, 1, 8'h10, 16'h0), rx(1, 0, 8'hf0, 16'h0), ADSEL_TOP);
    ev(rx(1, 1, 8'h10, 16'h0), rx(1, 1, 8'hf0, 16'h0), ADSEL_BOT);
    ev(rx(1, 0, 8'h10, 16'h0), rx(1, 0, 8'hf0, 16'h0), ADSEL_NONE);
    use_msg = 0;
  endtask : t_msg
  // two events in consecutive cycles, each answered one cycle later
  task automatic t_b2b();
    t_in = rx(1, 0, 8'h10, 16'h0);
    b_in = rx(0, 0, 8'hff, 16'h0);
    fire = 1;
    @(posedge clk);
    #1 t_in = rx(0, 0, 8'hff, 16'h0);
    b_in = rx(1, 0, 8'h10, 16'h0);
    chk("b2b_sel1", sel_r, ADSEL_TOP);
    chk("b2b_out1", {sel_strobe_r, tx_key_r}, 2'h3);
    @(posedge clk);
    #1 fire = 0;
    chk("b2b_sel2", sel_r, ADSEL_BOT);
    chk("b2b_out2", {sel_strobe_r, tx_key_r}, 2'h3);
    @(posedge clk);
    #1;
    chk("b2b_idle", {sel_strobe_r, tx_key_r}, 2'h0);
  endtask : t_b2b
  // reset in mid-run with an event pending: reset wins, choice cleared
  task automatic t_rst();
    ev(rx(1, 0, 8'h10, 16'h0), rx(0, 0, 8'hff, 16'h0), ADSEL_TOP);
    t_in = rx(0, 0, 8'hff, 16'h0);
    b_in = rx(1, 0, 8'h10, 16'h0);
    fire = 1;
    sys_rst = 1;
    @(posedge clk);
    #1 sys_rst = 0;
    fire = 0;
    chk("rst_sel", sel_r, ADSEL_NONE);
    chk("rst_out", {sel_strobe_r, tx_key_r}, 2'h0);
    @(posedge clk);
    #1;
    chk("rst_hold", sel_r, ADSEL_NONE);
    chk("rst_idle", {sel_strobe_r, tx_key_r}, 2'h0);
  endtask : t_rst
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // hang guard, far above the few dozen cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 500)
    begin
      num_errors++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    #1 sys_rst = 0;
    chk("rst", sel_r, ADSEL_NONE);
    chk("rst_strobes", {sel_strobe_r, tx_key_r}, 2'h0);
    t_single();
    t_amp();
    t_skew();
    t_tie();
    t_b2b();
    t_rst();
    t_none();
    t_msg();
    end_of_test();
  end
endmodule : tb_adsel

`default_nettype wire
